// [src/rt_irq_queue_pkg.sv]
/*
  Shared constants and types for the terminal non-message interrupt and queue block.
  Assumes a 16-bit register port with word addresses and a 16-bit shared memory port.
*/
`default_nettype none
package rt_irq_queue_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int REG_AW = 3;

  // Register indices on the plain register port.
  localparam logic [REG_AW-1:0] REG_IRQ_MASK1 = 3'h0;
  localparam logic [REG_AW-1:0] REG_IRQ_STAT1 = 3'h1;
  localparam logic [REG_AW-1:0] REG_CONFIG2 = 3'h2;
  localparam logic [REG_AW-1:0] REG_CONFIG6 = 3'h3;
  localparam logic [REG_AW-1:0] REG_TIME_TAG = 3'h4;
  localparam logic [REG_AW-1:0] REG_STATUS_WORD = 3'h5;
  localparam logic [REG_AW-1:0] REG_QUEUE_PTR = 3'h6;

  // Bit positions.
  localparam int BIT_TT_WRAP = 6;
  localparam int BIT_ADDR_PARITY = 7;
  localparam int BIT_MEM_PARITY = 14;
  localparam int BIT_SELF_TEST = 13;
  localparam int BIT_QUEUE_EN = 6;
  localparam int BIT_AUTO_SRQ_CLR = 2;
  localparam int BIT_SYNC_TT_CLR = 6;
  localparam int BIT_ENH_IRQ = 15;
  localparam int BIT_SVC_REQ = 8;

  // Non-message event bits; the reserved bits of mask and status stay zero.
  localparam logic [DATA_W-1:0] NONMSG_BITS = 16'h60C0;
  localparam logic [DATA_W-1:0] RESET_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] TT_CLEAR_VAL = 16'h0000;
  localparam logic [DATA_W-1:0] TT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] TT_MAX = 16'hFFFF;
  localparam logic [7:0] QPTR_ONE = 8'h01;
  localparam logic [7:0] QPTR_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] QUEUE_BASE = 16'h0100;

  typedef enum logic [1:0] {PORT_IDLE, PORT_READ, PORT_LOAD, PORT_WRITE} memPort_e;

  typedef struct packed {
    logic valid;
    logic txVector;
    logic syncNoData;
  } msgEnd_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } memReq_s;
endpackage
`default_nettype wire

// [src/rt_irq_queue.sv]
/*
  Remote terminal non-message interrupts, interrupt status queue writes, the transmit
  data word fetch into the encoder register, and the end-of-message mode code effects.
  Assumes one 25 MHz clock, synchronous inputs, a shared memory that returns read data
  in the cycle after a read strobe and accepts a write in one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module rt_irq_queue
  import rt_irq_queue_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  input wire logic timeTagTick,
  input wire logic terminal_addr_parity_fault,
  input wire logic memParityFault,
  input wire logic selfTestBusy,
  input wire logic selfTestDone,
  input wire logic txWordReq,
  input wire logic [ADDR_W-1:0] txWordAddr,
  input wire msgEnd_s message_end_sequence,
  output memReq_s memReq,
  input wire logic [DATA_W-1:0] memRdData,
  output logic [DATA_W-1:0] encData,
  output logic encLoad,
  output logic [DATA_W-1:0] statusWord,
  output logic respondEnable,
  output logic irqReq
);
  logic [DATA_W-1:0] irqMask;
  logic [DATA_W-1:0] irqStat;
  logic [DATA_W-1:0] config2;
  logic [DATA_W-1:0] config6;
  logic [DATA_W-1:0] timeTag;
  logic [7:0] queuePtr;
  logic [DATA_W-1:0] queuePend;
  logic [DATA_W-1:0] events;
  logic [DATA_W-1:0] statSet;
  logic [DATA_W-1:0] queueSet;
  logic [DATA_W-1:0] served;
  logic fetchPend;
  logic [ADDR_W-1:0] fetchAddr;
  logic ttWrap;
  logic clearSrq;
  logic clearTt;
  memPort_e portState;

  // Isolates the lowest pending bit, so one event leaves per queue write.
  function automatic logic [DATA_W-1:0] lowest_bit(input logic [DATA_W-1:0] v);
    return v & (~v + TT_ONE);
  endfunction

  function automatic logic reg_hit(input logic strobe, input logic [REG_AW-1:0] a,
                                   input logic [REG_AW-1:0] target);
    return strobe && (a == target);
  endfunction

  assign ttWrap = timeTagTick && (timeTag == TT_MAX);
  assign clearSrq = message_end_sequence.valid && message_end_sequence.txVector
                    && config2[BIT_AUTO_SRQ_CLR];
  assign clearTt = message_end_sequence.valid && message_end_sequence.syncNoData
                   && config2[BIT_SYNC_TT_CLR];

  always_comb begin
    events = RESET_ZERO;
    events[BIT_TT_WRAP] = ttWrap;
    events[BIT_ADDR_PARITY] = terminal_addr_parity_fault;
    events[BIT_MEM_PARITY] = memParityFault;
    events[BIT_SELF_TEST] = selfTestDone;
  end

  // Enhanced mode logs every event; otherwise only enabled ones reach the status.
  assign statSet = config2[BIT_ENH_IRQ] ? events : (events & irqMask);
  assign queueSet = config6[BIT_QUEUE_EN] ? (events & irqMask) : RESET_ZERO;
  // Queue entries leave only from an idle port with no word fetch waiting, so a queue
  // write never lands between a fetch and its encoder load.
  assign served = (portState == PORT_IDLE && !fetchPend) ? lowest_bit(queuePend) : RESET_ZERO;
  assign respondEnable = !selfTestBusy;
  assign irqReq = |(irqStat & irqMask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask <= RESET_ZERO;
      config2 <= RESET_ZERO;
      config6 <= RESET_ZERO;
    end else begin
      if (reg_hit(regWr, regAddr, REG_IRQ_MASK1)) begin
        irqMask <= regWrData & NONMSG_BITS;
      end
      if (reg_hit(regWr, regAddr, REG_CONFIG2)) begin
        config2 <= regWrData;
      end
      if (reg_hit(regWr, regAddr, REG_CONFIG6)) begin
        config6 <= regWrData;
      end
    end
  end

  // Status bits clear on a written one; a new event in the same cycle wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat <= RESET_ZERO;
    end else if (reg_hit(regWr, regAddr, REG_IRQ_STAT1)) begin
      irqStat <= (irqStat & ~regWrData) | statSet;
    end else begin
      irqStat <= irqStat | statSet;
    end
  end

  // The message-end clears act on their own and never wait for the memory port.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeTag <= TT_CLEAR_VAL;
    end else if (clearTt) begin
      timeTag <= TT_CLEAR_VAL;
    end else if (reg_hit(regWr, regAddr, REG_TIME_TAG)) begin
      timeTag <= regWrData;
    end else if (timeTagTick) begin
      timeTag <= timeTag + TT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusWord <= RESET_ZERO;
    end else if (clearSrq) begin
      statusWord[BIT_SVC_REQ] <= 1'b0;
    end else if (reg_hit(regWr, regAddr, REG_STATUS_WORD)) begin
      statusWord <= regWrData;
    end
  end

  // Pending queue entries; a new event wins over the entry being served.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      queuePend <= RESET_ZERO;
    end else begin
      queuePend <= (queuePend & ~served) | queueSet;
    end
  end

  // A word request outside self-test waits until the port has taken it; one during self-test is dropped.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchPend <= 1'b0;
      fetchAddr <= RESET_ZERO;
    end else if (txWordReq && respondEnable) begin
      fetchPend <= 1'b1;
      fetchAddr <= txWordAddr;
    end else if (portState == PORT_IDLE) begin
      fetchPend <= 1'b0;
    end
  end

  // Memory port: a waiting word fetch wins over a queue write; the encoder only ever takes read data.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portState <= PORT_IDLE;
      memReq <= '0;
      encData <= RESET_ZERO;
      encLoad <= 1'b0;
      queuePtr <= QPTR_ZERO;
    end else begin
      memReq.rd <= 1'b0;
      memReq.wr <= 1'b0;
      encLoad <= 1'b0;
      case (portState)
        PORT_IDLE: begin
          if (fetchPend) begin
            memReq.rd <= 1'b1;
            memReq.addr <= fetchAddr;
            portState <= PORT_READ;
          end else if (served != RESET_ZERO) begin
            memReq.wr <= 1'b1;
            memReq.addr <= QUEUE_BASE + {8'h00, queuePtr};
            memReq.data <= served;
            queuePtr <= queuePtr + QPTR_ONE;
            portState <= PORT_WRITE;
          end
        end
        PORT_READ: begin
          portState <= PORT_LOAD;
        end
        PORT_LOAD: begin
          encData <= memRdData;
          encLoad <= 1'b1;
          portState <= PORT_IDLE;
        end
        PORT_WRITE: begin
          portState <= PORT_IDLE;
        end
        default: begin
          portState <= PORT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= RESET_ZERO;
    end else if (regRd) begin
      case (regAddr)
        REG_IRQ_MASK1: regRdData <= irqMask;
        REG_IRQ_STAT1: regRdData <= irqStat;
        REG_CONFIG2: regRdData <= config2;
        REG_CONFIG6: regRdData <= config6;
        REG_TIME_TAG: regRdData <= timeTag;
        REG_STATUS_WORD: regRdData <= statusWord;
        REG_QUEUE_PTR: regRdData <= {8'h00, queuePtr};
        default: regRdData <= RESET_ZERO;
      endcase
    end else begin
      regRdData <= RESET_ZERO;
    end
  end

  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    memReq.wr |-> (memReq.data & ~NONMSG_BITS) == RESET_ZERO)
    else $error("queue entry outside the non-message bits");

  queue_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (config6[BIT_QUEUE_EN] && terminal_addr_parity_fault && irqMask[BIT_ADDR_PARITY] && !ttWrap
     && !txWordReq && !fetchPend && portState == PORT_IDLE && queuePend == RESET_ZERO)
    |=> ##1 (memReq.wr && memReq.data[BIT_ADDR_PARITY]))
    else $error("enabled event produced no queue write");

  encoder_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    memReq.rd |=> ##1 (encLoad && encData == $past(memRdData)))
    else $error("encoder not loaded with fetched word");

  encoder_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    encLoad |-> $past(portState) == PORT_LOAD && !$past(memReq.wr, 2))
    else $error("encoder loaded outside a fetch");

  srq_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (message_end_sequence.valid && message_end_sequence.txVector
     && config2[BIT_AUTO_SRQ_CLR]) |=> !statusWord[BIT_SVC_REQ])
    else $error("service request not cleared");

  tt_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (message_end_sequence.valid && message_end_sequence.syncNoData
     && config2[BIT_SYNC_TT_CLR]) |=> timeTag == TT_CLEAR_VAL)
    else $error("time tag not cleared");

  clear_amid_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (memReq.wr ##[1:5] clearTt) |=> timeTag == TT_CLEAR_VAL)
    else $error("clear lost next to queue write");

  enhanced_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ttWrap && config2[BIT_ENH_IRQ]) |=> irqStat[BIT_TT_WRAP])
    else $error("wrap status not set in enhanced mode");

  selftest_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    selfTestBusy |-> !respondEnable)
    else $error("responding during self-test");

  no_queue_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!config6[BIT_QUEUE_EN] && queuePend == RESET_ZERO) |=> !memReq.wr)
    else $error("queue write with queue disabled");

  encoder_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !encLoad |-> encData == $past(encData))
    else $error("encoder word changed without a load");

  queue_ptr_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    memReq.wr |-> queuePtr == $past(queuePtr) + QPTR_ONE)
    else $error("queue pointer did not advance");

  srq_amid_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (memReq.wr ##[1:5] clearSrq) |=> !statusWord[BIT_SVC_REQ])
    else $error("service request clear lost next to queue write");

  selftest_no_fetch_a: assert property (@(posedge clk) disable iff (!rst_b)
    (selfTestBusy && !fetchPend) |=> !fetchPend)
    else $error("word fetch started during self-test");

  selftest_status_a: assert property (@(posedge clk) disable iff (!rst_b)
    (selfTestDone && irqMask[BIT_SELF_TEST]) |=> irqStat[BIT_SELF_TEST])
    else $error("self-test done not logged");

  masked_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ttWrap && !config2[BIT_ENH_IRQ] && !irqMask[BIT_TT_WRAP] && !irqStat[BIT_TT_WRAP])
    |=> !irqStat[BIT_TT_WRAP])
    else $error("masked wrap logged outside enhanced mode");
endmodule
`default_nettype wire

// [tb/shared_mem_model.sv]
/*
  Shared memory seen by the terminal block: one-cycle read answer, one-cycle write.
  Assumes requests change only after rising clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
module shared_mem_model
  import rt_irq_queue_pkg::*;
(
  input wire logic clk,
  input wire memReq_s memReq,
  output logic [DATA_W-1:0] memRdData
);
  logic [DATA_W-1:0] mem [int];
  initial memRdData = 16'h0000;
  // Unwritten words read as address xor a pattern; off the answer cycle the lines toggle.
  always @(posedge clk) begin
    if (memReq.wr) begin
      mem[memReq.addr] = memReq.data;
    end
    if (memReq.rd) begin
      memRdData <= mem.exists(memReq.addr) ? mem[memReq.addr] : memReq.addr ^ 16'hA5A5;
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule
`default_nettype wire

// [tb/rt_irq_queue_mode_effects_bench.sv]
/*
  Self-checking bench for the terminal interrupt and queue block with a reference model.
  Assumes the shared memory model of this folder answers every read in one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module rt_irq_queue_mode_effects_bench
  import rt_irq_queue_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, txWordReq = 1'b0;
  logic selfTestBusy = 1'b0, encLoad, respondEnable, irqReq;
  logic [REG_AW-1:0] regAddr = 3'h0;
  logic [DATA_W-1:0] regWrData = 16'h0000, txWordAddr = 16'h0000;
  logic [DATA_W-1:0] memRdData, regRdData, encData, statusWord;
  logic [DATA_W-1:0] mask = 16'h0000, cfg2 = 16'h0000, cfg6 = 16'h0000, stat = 16'h0000;
  logic [3:0] ev = 4'h0;
  logic [31:0] seed = 32'h0000_0017;
  logic [31:0] wq [$];
  logic [DATA_W-1:0] eq [$];
  msgEnd_s me = 3'h0;
  memReq_s memReq;
  int qptr = 0, err_count = 0, num_checks = 0;
  int bits [4] = '{BIT_TT_WRAP, BIT_ADDR_PARITY, BIT_MEM_PARITY, BIT_SELF_TEST};
  always #20 clk = ~clk;
  rt_irq_queue dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .timeTagTick(ev[0]),
    .terminal_addr_parity_fault(ev[1]), .memParityFault(ev[2]),
    .selfTestBusy(selfTestBusy), .selfTestDone(ev[3]), .txWordReq(txWordReq),
    .txWordAddr(txWordAddr), .message_end_sequence(me), .memReq(memReq),
    .memRdData(memRdData), .encData(encData), .encLoad(encLoad), .statusWord(statusWord),
    .respondEnable(respondEnable), .irqReq(irqReq));
  shared_mem_model mem (.clk(clk), .memReq(memReq), .memRdData(memRdData));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Every queue write and encoder load must be the next one the model predicts.
  always @(posedge clk) begin
    if (memReq.wr === 1'b1) begin
      chk(wq.size() > 0 && {memReq.addr, memReq.data} === wq[0], "queue");
      if (wq.size() > 0) void'(wq.pop_front());
    end
    if (encLoad === 1'b1) begin
      chk(eq.size() > 0 && encData === eq[0], "encoder word");
      if (eq.size() > 0) void'(eq.pop_front());
    end
  end
  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    case (a)
      REG_IRQ_MASK1: mask = d & NONMSG_BITS;
      REG_IRQ_STAT1: stat = stat & ~d;
      REG_CONFIG2: cfg2 = d;
      REG_CONFIG6: cfg6 = d;
      default: ;
    endcase
    @(posedge clk);
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] e, input string m);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData === e, m);
    @(posedge clk);
  endtask
  task automatic predict(input int i);
    if (mask[bits[i]] && cfg6[BIT_QUEUE_EN]) begin
      wq.push_back({QUEUE_BASE + 16'(qptr), 16'h0001 << bits[i]});
      qptr++;
    end
    if (mask[bits[i]] || cfg2[BIT_ENH_IRQ]) stat[bits[i]] = 1'b1;
  endtask
  task automatic fire(input int i);
    predict(i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle();
    for (int k = 0; k < 30 && wq.size() + eq.size() > 0; k++) @(posedge clk);
    if (wq.size() + eq.size() != 0) begin
      err_count++;
      $display("mismatch at %0t: expected transfer never came", $time);
      tally_and_finish();
    end
    rd(REG_IRQ_STAT1, stat, "status bits");
    chk(irqReq === |(stat & mask), "interrupt request");
    wr(REG_IRQ_STAT1, 16'hFFFF);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(memReq === '0 && regRdData === 16'h0000 && encLoad === 1'b0, "reset outputs");
    @(posedge clk);
    wr(REG_IRQ_MASK1, 16'hFFFF);
    rd(REG_IRQ_MASK1, mask, "mask readback");
    rd(3'h7, 16'h0000, "unmapped read");
    wr(REG_CONFIG6, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      wr(REG_TIME_TAG, 16'hFFFF);
      fire(i);
      settle();
    end
    $display("event queue test done");
    for (int c = 0; c < 3; c++) begin
      wr(REG_IRQ_MASK1, c == 1 ? 16'hFFFF : 16'h0000);
      wr(REG_CONFIG6, c == 1 ? 16'h0000 : 16'h0040);
      wr(REG_CONFIG2, c == 2 ? 16'h8000 : 16'h0000);
      wr(REG_TIME_TAG, 16'hFFFF);
      fire(0);
      fire(1);
      settle();
    end
    $display("masked and enhanced test done");
    wr(REG_CONFIG2, 16'h0000);
    wr(REG_IRQ_MASK1, 16'hFFFF);
    wr(REG_CONFIG6, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      txWordAddr <= {8'h08, seed[7:0]};
      txWordReq <= 1'b1;
      eq.push_back({8'h08, seed[7:0]} ^ 16'hA5A5);
      if (i < 2) predict(1);
      if (i < 2) ev[1] <= 1'b1;
      @(posedge clk);
      txWordReq <= 1'b0;
      ev[1] <= 1'b0;
      settle();
    end
    $display("fetch test done");
    selfTestBusy <= 1'b1;
    txWordReq <= 1'b1;
    @(posedge clk);
    txWordReq <= 1'b0;
    #1;
    chk(respondEnable === 1'b0, "response during self-test");
    repeat (4) @(posedge clk);
    selfTestBusy <= 1'b0;
    fire(3);
    settle();
    $display("self-test test done");
    for (int c = 0; c < 2; c++) begin
      wr(REG_CONFIG2, c == 1 ? 16'h0044 : 16'h0000);
      wr(REG_STATUS_WORD, 16'h0100);
      wr(REG_TIME_TAG, 16'h1234);
      fire(1);
      seed = xs(seed);
      repeat (1 + seed[1:0]) @(posedge clk);
      me <= 3'h7;
      @(posedge clk);
      me <= 3'h0;
      #1;
      chk(statusWord[BIT_SVC_REQ] === (c == 0), "service request after end");
      @(posedge clk);
      rd(REG_TIME_TAG, c == 1 ? 16'h0000 : 16'h1234, "time tag after end");
      settle();
    end
    $display("message end test done");
    rd(REG_QUEUE_PTR, {8'h00, 8'(qptr)}, "queue pointer");
    tally_and_finish();
  end
endmodule
`default_nettype wire
